/* rqsp_app_model.sv */
// rqsp_app_model: application side of the request stream, sends request packets
// assumes: accept is sampled at the rising edge of pclk, like every other input of the port
`timescale 1ns/100ps
`default_nettype none

module rqsp_app_model (
    input wire logic pclk,
    input wire logic [3:0] request_stream_accept,
    output logic [255:0] request_stream_data,
    output logic [59:0] request_stream_sideband,
    output logic request_stream_end,
    output logic [7:0] request_stream_dword_keep,
    output logic request_stream_present
);
    initial
    begin
        request_stream_data = 256'h0;
        request_stream_sideband = 60'h0;
        request_stream_end = 1'b0;
        request_stream_dword_keep = 8'h00;
        request_stream_present = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // present stays up from packet to packet; idle() is the only release
    task send(input int nbeats, input logic [7:0] last_keep, input logic [3:0] seq);
        for (int b = 0; b < nbeats; b++)
        begin
            request_stream_data <= {32{8'(16 * seq + b)}};
            request_stream_sideband <= {15{seq}};
            request_stream_end <= (b == nbeats - 1);
            request_stream_dword_keep <= (b == nbeats - 1) ? last_keep : 8'hff;
            request_stream_present <= 1'b1;
            // the beat stands until the rising edge that sees accept high
            do
            begin
                @(posedge pclk);
            end
            while (request_stream_accept[0] !== 1'b1);
        end
    endtask : send

    // released end, data and sideband lines show the inverse so stale beats can not pass for fresh ones; keep holds its value
    task idle();
        request_stream_present <= 1'b0;
        request_stream_end <= ~request_stream_end;
        request_stream_data <= ~request_stream_data;
        request_stream_sideband <= ~request_stream_sideband;
        @(posedge pclk);
    endtask : idle
endmodule : rqsp_app_model

`default_nettype wire

/* rqsp_pkg.sv */
// rqsp_pkg: constants shared by the request stream port and its progress pipe
// assumes: one clock domain (pclk), registers reached over apb with 32-bit data
package rqsp_pkg;

    localparam int RQSP_DATA_MAX_W = 32'h0000_0100;
    localparam int RQSP_KEEP_W = 32'h0000_0008;
    localparam int RQSP_SIDEBAND_W = 32'h0000_003c;
    localparam int RQSP_ACCEPT_W = 32'h0000_0004;
    localparam int RQSP_PROGRESS_W = 32'h0000_0004;
    localparam int RQSP_DWORD_W = 32'h0000_0020;
    localparam int RQSP_IF_W_DEFAULT = 32'h0000_0100;
    // sideband position of the progress number
    localparam int RQSP_PROGRESS_LSB = 32'h0000_0018;
    // cycles from the end beat leaving the port until the request can not be passed
    localparam int RQSP_PROGRESS_DEPTH = 32'h0000_0003;

    ////////////////////////////////////////////////////////////////////////////
    localparam int RQSP_ADDR_W = 32'h0000_000c;
    localparam logic [11:0] RQSP_CTRL_OFS = 12'h000;
    localparam logic [11:0] RQSP_STATUS_OFS = 12'h004;
    localparam logic [11:0] RQSP_PKT_COUNT_OFS = 12'h008;
    localparam logic [11:0] RQSP_BEAT_COUNT_OFS = 12'h00c;

    localparam int RQSP_CTRL_ACCEPT_EN_BIT = 32'h0000_0000;
    localparam int RQSP_CTRL_PROGRESS_EN_BIT = 32'h0000_0001;
    localparam int RQSP_CTRL_CLEAR_BIT = 32'h0000_0002;
    localparam logic RQSP_CTRL_ACCEPT_EN_RST = 1'h1;
    localparam logic RQSP_CTRL_PROGRESS_EN_RST = 1'h1;

    localparam int RQSP_STATUS_IN_PACKET_BIT = 32'h0000_0000;
    localparam int RQSP_STATUS_TX_VALID_BIT = 32'h0000_0001;
    localparam int RQSP_STATUS_ACCEPT_BIT = 32'h0000_0002;
    localparam int RQSP_STATUS_LAST_PROGRESS_LSB = 32'h0000_0004;

    typedef enum logic [0:0]
    {
        RQSP_IDLE = 1'b0,
        RQSP_MID = 1'b1
    } rqsp_state_type;

endpackage : rqsp_pkg

/* rqsp_progress_if.sv */
// rqsp_progress_if: progress numbers entering and leaving the transmit pipe
// assumes: both ends clocked by the same pclk
`timescale 1ns/100ps
`default_nettype none

interface rqsp_progress_if;
    logic [3:0] in_num;
    logic in_strobe;
    logic [3:0] out_num;
    logic out_strobe;

    modport pipe
    (
        input in_num,
        input in_strobe,
        output out_num,
        output out_strobe
    );

    modport port
    (
        output in_num,
        output in_strobe,
        input out_num,
        input out_strobe
    );
endinterface : rqsp_progress_if

`default_nettype wire

/* rqsp_progress_pipe.sv */
// rqsp_progress_pipe: fixed delay line carrying progress numbers past the
// point where a later completion can no longer overtake the request
// assumes: clock enable freezes every stage together
`timescale 1ns/100ps
`default_nettype none

module rqsp_progress_pipe #(
    parameter int DEPTH = rqsp_pkg::RQSP_PROGRESS_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    rqsp_progress_if.pipe prog
);

    generate
        if (DEPTH < 1)
        begin : g_bad_depth
            $error("rqsp_progress_pipe: DEPTH must be at least 1");
        end
    endgenerate

    logic [3:0] num_q [DEPTH];
    logic [DEPTH-1:0] vld_q;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vld_q <= '0;
            for (int i = 0; i < DEPTH; i++)
            begin
                num_q[i] <= 4'h0;
            end
        end
        else if (ce)
        begin
            vld_q[0] <= prog.in_strobe;
            num_q[0] <= prog.in_num;
            for (int i = 1; i < DEPTH; i++)
            begin
                vld_q[i] <= vld_q[i-1];
                num_q[i] <= num_q[i-1];
            end
        end
    end

    // one stage per entry, so each number gives one enabled strobe cycle; the strobe stays up for as long as ce is low
    assign prog.out_strobe = vld_q[DEPTH-1];
    assign prog.out_num = num_q[DEPTH-1];

    ////////////////////////////////////////////////////////////////////////////
    AST_PROGRESS_ECHO: assert property (
        @(posedge pclk iff ce) disable iff (!presetn)
        prog.in_strobe |-> ##DEPTH (prog.out_strobe && prog.out_num == $past(prog.in_num, DEPTH)))
    else $error("progress number not echoed after pipe depth");

    AST_STROBE_ONE_PER_ENTRY: assert property (
        @(posedge pclk iff ce) disable iff (!presetn)
        prog.out_strobe |-> $past(prog.in_strobe, DEPTH))
    else $error("progress strobe without a matching entry");

endmodule : rqsp_progress_pipe

`default_nettype wire

/* rqsp_request_port.sv */
// rqsp_request_port: request stream port of the core; takes request beats from
// the application, masks them to the configured width, forwards them to the
// transmit pipeline and echoes progress numbers once requests are safe
// assumes: application and transmit side share pclk; apb master on pclk
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rqsp_request_port #(
    parameter int IF_W = rqsp_pkg::RQSP_IF_W_DEFAULT,
    parameter int PROGRESS_DEPTH = rqsp_pkg::RQSP_PROGRESS_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [255:0] request_stream_data,
    input wire logic [59:0] request_stream_sideband,
    input wire logic request_stream_end,
    input wire logic [7:0] request_stream_dword_keep,
    input wire logic request_stream_present,
    output logic [3:0] request_stream_accept,
    output logic [3:0] request_progress_out,
    output logic request_progress_strobe,
    output logic [255:0] tx_data,
    output logic [7:0] tx_keep,
    output logic [59:0] tx_sideband,
    output logic tx_end,
    output logic tx_valid,
    input wire logic tx_ready
);

    generate
        if (IF_W != 64 && IF_W != 128 && IF_W != 256)
        begin : g_bad_width
            $error("rqsp_request_port: IF_W must be 64, 128 or 256");
        end
    endgenerate

    // upper lanes are dead at narrow widths, whatever the application drives
    localparam logic [255:0] DATA_MASK = (IF_W == 256) ? {256{1'b1}} :
        (IF_W == 128) ? {128'h0, {128{1'b1}}} : {192'h0, {64{1'b1}}};
    localparam logic [7:0] KEEP_MASK = (IF_W == 256) ? 8'hff :
        (IF_W == 128) ? 8'h0f : 8'h03;
    localparam int PLSB = rqsp_pkg::RQSP_PROGRESS_LSB;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic accept_en_q;
    logic progress_en_q;
    logic clear_q;
    logic [31:0] pkt_count_q;
    logic [31:0] beat_count_q;
    logic [3:0] last_progress_q;
    logic [31:0] prdata_q;
    logic rd_armed_q;

    // datapath
    rqsp_pkg::rqsp_state_type state_q;
    rqsp_pkg::rqsp_state_type state_d;
    logic [3:0] seq_hold_q;
    logic [3:0] tx_seq_q;
    logic [255:0] tx_data_q;
    logic [7:0] tx_keep_q;
    logic [59:0] tx_sideband_q;
    logic tx_end_q;
    logic tx_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // stream handshake
    wire accept = ce && accept_en_q && (!tx_valid_q || tx_ready);
    wire beat_fire = request_stream_present && accept;
    wire tx_fire = ce && tx_valid_q && tx_ready;
    wire packet_done = beat_fire && request_stream_end;
    wire [3:0] side_seq = request_stream_sideband[PLSB +: 4];
    wire [3:0] seq_cur = (state_q == rqsp_pkg::RQSP_IDLE) ? side_seq : seq_hold_q;
    wire [255:0] data_masked = request_stream_data & DATA_MASK;
    wire [7:0] keep_masked = request_stream_dword_keep & KEEP_MASK;

    assign request_stream_accept = {4{accept}};

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            rqsp_pkg::RQSP_IDLE:
            begin
                if (beat_fire && !request_stream_end)
                begin
                    state_d = rqsp_pkg::RQSP_MID;
                end
            end
            rqsp_pkg::RQSP_MID:
            begin
                if (packet_done)
                begin
                    state_d = rqsp_pkg::RQSP_IDLE;
                end
            end
            default:
            begin
                state_d = rqsp_pkg::RQSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= rqsp_pkg::RQSP_IDLE;
            seq_hold_q <= 4'h0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            if (beat_fire)
            begin
                seq_hold_q <= seq_cur;
            end
        end
    end

    // output stage: loads on a moved beat, holds while the transmit side stalls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_data_q <= 256'h0;
            tx_keep_q <= 8'h0;
            tx_sideband_q <= 60'h0;
            tx_end_q <= 1'h0;
            tx_seq_q <= 4'h0;
        end
        else if (beat_fire)
        begin
            tx_data_q <= data_masked;
            tx_keep_q <= keep_masked;
            tx_sideband_q <= request_stream_sideband;
            tx_end_q <= request_stream_end;
            tx_seq_q <= seq_cur;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_valid_q <= 1'h0;
        end
        else if (ce)
        begin
            tx_valid_q <= beat_fire || (tx_valid_q && !tx_ready);
        end
    end

    assign tx_data = tx_data_q;
    assign tx_keep = tx_keep_q;
    assign tx_sideband = tx_sideband_q;
    assign tx_end = tx_end_q;
    assign tx_valid = tx_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // progress: numbers enter the pipe as the end beat leaves the port
    rqsp_progress_if prog_if ();

    assign prog_if.in_strobe = tx_fire && tx_end_q && progress_en_q;
    assign prog_if.in_num = tx_seq_q;
    assign request_progress_out = prog_if.out_num;
    assign request_progress_strobe = prog_if.out_strobe;

    rqsp_progress_pipe #(
        .DEPTH(PROGRESS_DEPTH)
    ) u_progress_pipe (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .prog(prog_if.pipe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: read data captured once per transfer, pready follows it
    wire sel_ctrl = paddr == rqsp_pkg::RQSP_CTRL_OFS;
    wire sel_status = paddr == rqsp_pkg::RQSP_STATUS_OFS;
    wire sel_pkt = paddr == rqsp_pkg::RQSP_PKT_COUNT_OFS;
    wire sel_beat = paddr == rqsp_pkg::RQSP_BEAT_COUNT_OFS;
    wire addr_hit = sel_ctrl || sel_status || sel_pkt || sel_beat;
    wire apb_done = psel && penable && pready;
    wire ctrl_write = apb_done && pwrite && sel_ctrl && pstrb[0];
    wire [31:0] ctrl_rd = {30'h0, progress_en_q, accept_en_q};
    wire [31:0] status_rd = {24'h0, last_progress_q, 1'h0, accept, tx_valid_q, state_q == rqsp_pkg::RQSP_MID};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_rd : sel_status ? status_rd :
        sel_pkt ? pkt_count_q : sel_beat ? beat_count_q : 32'h0;

    assign pready = ce && psel && penable && (pwrite || rd_armed_q);
    assign pslverr = pready && !addr_hit;
    assign prdata = prdata_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0;
            rd_armed_q <= 1'h0;
        end
        else if (ce)
        begin
            if (apb_done)
            begin
                rd_armed_q <= 1'h0;
            end
            else if (psel && !pwrite && !rd_armed_q)
            begin
                prdata_q <= rd_mux;
                rd_armed_q <= 1'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            accept_en_q <= rqsp_pkg::RQSP_CTRL_ACCEPT_EN_RST;
            progress_en_q <= rqsp_pkg::RQSP_CTRL_PROGRESS_EN_RST;
            clear_q <= 1'h0;
        end
        else if (ce)
        begin
            clear_q <= ctrl_write && pwdata[rqsp_pkg::RQSP_CTRL_CLEAR_BIT];
            if (ctrl_write)
            begin
                accept_en_q <= pwdata[rqsp_pkg::RQSP_CTRL_ACCEPT_EN_BIT];
                progress_en_q <= pwdata[rqsp_pkg::RQSP_CTRL_PROGRESS_EN_BIT];
            end
        end
    end

    // a beat that lands in the clear cycle still counts
    wire [31:0] beat_base = clear_q ? 32'h0 : beat_count_q;
    wire [31:0] pkt_base = clear_q ? 32'h0 : pkt_count_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            beat_count_q <= 32'h0;
            pkt_count_q <= 32'h0;
            last_progress_q <= 4'h0;
        end
        else if (ce)
        begin
            beat_count_q <= beat_base + {31'h0, beat_fire};
            pkt_count_q <= pkt_base + {31'h0, packet_done};
            if (prog_if.out_strobe)
            begin
                last_progress_q <= prog_if.out_num;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_ACCEPT_UNIFORM: assert property (
        @(posedge pclk) disable iff (!presetn)
        request_stream_accept == 4'h0 || request_stream_accept == 4'hf)
    else $error("accept bits disagree");

    AST_DATA_MASKED: assert property (
        @(posedge pclk) disable iff (!presetn)
        beat_fire |=> tx_data == ($past(request_stream_data) & DATA_MASK))
    else $error("forwarded data not masked to interface width");

    AST_KEEP_MASKED: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_valid |-> (tx_keep & ~KEEP_MASK) == 8'h0)
    else $error("keep bits above configured lanes forwarded");

    AST_SIDEBAND_CAPTURE: assert property (
        @(posedge pclk) disable iff (!presetn)
        beat_fire |=> tx_sideband == $past(request_stream_sideband) && tx_valid)
    else $error("sideband not taken with its beat");

    AST_STALL_HOLDS: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_data) && $stable(tx_end))
    else $error("output beat changed while stalled");

    AST_BEAT_COUNTS: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && !clear_q) |=> beat_count_q == $past(beat_count_q) + {31'h0, $past(beat_fire)})
    else $error("beat counter disagrees with handshake");

    AST_FIRST_BEAT_NUMBER: assert property (
        @(posedge pclk) disable iff (!presetn)
        (beat_fire && state_q == rqsp_pkg::RQSP_IDLE) |=> tx_seq_q == $past(side_seq))
    else $error("progress number not taken from first beat");

    AST_NO_ACCEPT_DISABLED: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl_write && !pwdata[0]) |=> request_stream_accept == 4'h0 [*2])
    else $error("beats accepted while disabled");

    COV_SINGLE_BEAT: cover property (
        @(posedge pclk) disable iff (!presetn)
        beat_fire && request_stream_end && state_q == rqsp_pkg::RQSP_IDLE);

    COV_STALL_MID_PACKET: cover property (
        @(posedge pclk) disable iff (!presetn)
        state_q == rqsp_pkg::RQSP_MID && request_stream_present && !accept);

    COV_PROGRESS_ECHO: cover property (
        @(posedge pclk) disable iff (!presetn)
        request_progress_strobe ##1 !request_progress_strobe);

endmodule : rqsp_request_port

`default_nettype wire

/* rqsp_request_port_test.sv */
// rqsp_request_port_test: drives packets and apb accesses, checks the transmit side
// assumes: the port is built 128 bits wide so the upper lanes must come out as zero
`timescale 1ns/100ps
`default_nettype none

module rqsp_request_port_test;
    localparam int IF_W = 128;
    localparam int BW = 325;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, tx_ready, stall, prog_en, first_beat;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, request_stream_accept, request_progress_out;
    logic [255:0] request_stream_data, tx_data;
    logic [59:0] request_stream_sideband, tx_sideband;
    logic [7:0] request_stream_dword_keep, tx_keep;
    logic request_stream_end, request_stream_present, request_progress_strobe, tx_end, tx_valid, err;
    logic [BW-1:0] exp_q[$];
    logic [3:0] prog_q[$];
    int n_errors, checks_done, cycles, beats_in, pkts_in, n;

    rqsp_request_port #(.IF_W(IF_W), .PROGRESS_DEPTH(3)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .request_stream_data(request_stream_data),
        .request_stream_sideband(request_stream_sideband), .request_stream_end(request_stream_end),
        .request_stream_dword_keep(request_stream_dword_keep), .request_stream_present(request_stream_present),
        .request_stream_accept(request_stream_accept), .request_progress_out(request_progress_out),
        .request_progress_strobe(request_progress_strobe), .tx_data(tx_data), .tx_keep(tx_keep),
        .tx_sideband(tx_sideband), .tx_end(tx_end), .tx_valid(tx_valid), .tx_ready(tx_ready));

    rqsp_app_model app (.pclk(pclk), .request_stream_accept(request_stream_accept),
        .request_stream_data(request_stream_data), .request_stream_sideband(request_stream_sideband),
        .request_stream_end(request_stream_end), .request_stream_dword_keep(request_stream_dword_keep),
        .request_stream_present(request_stream_present));

    ////////////////////////////////////////////////////////////////////////////
    task stop_test();
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task check_val(input logic [BW-1:0] got, input logic [BW-1:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: stream value %h, expected %h", $time, got, exp);
        end
    endtask : check_val

    task check_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: register value %h, expected %h", $time, got, exp);
        end
    endtask : check_reg

    // pready, read data and error are all taken at the rising edge that ends the access
    task apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb_xfer

    task drain();
        while (exp_q.size() != 0 || prog_q.size() != 0)
            @(posedge pclk);
    endtask : drain

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        tx_ready <= !stall || (cycles % 3 == 0);
        if (cycles == 20000)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            stop_test();
        end
    end

    // reference beats are taken at the input handshake, masked to the built width
    always @(negedge pclk)
    begin
        if (presetn)
        begin
            check_val(BW'(request_stream_accept), request_stream_accept[0] ? 4'hf : 4'h0);
            if (!ce)
                check_val(BW'(request_stream_accept), BW'(0));
            if (request_stream_present && request_stream_accept[0])
            begin
                exp_q.push_back({request_stream_end, request_stream_sideband,
                    request_stream_dword_keep & (8'hff >> (8 - IF_W / 32)),
                    request_stream_data & ({256{1'b1}} >> (256 - IF_W))});
                beats_in++;
                pkts_in += request_stream_end;
                if (first_beat && prog_en)
                    prog_q.push_back(request_stream_sideband[rqsp_pkg::RQSP_PROGRESS_LSB +: 4]);
                first_beat = request_stream_end;
            end
            // with ce low the port is frozen, so a beat only leaves on an enabled cycle
            if (ce && tx_valid && tx_ready)
            begin
                check_val(BW'(exp_q.size() != 0), BW'(1));
                if (exp_q.size() != 0)
                    check_val({tx_end, tx_sideband, tx_keep, tx_data}, exp_q.pop_front());
            end
            if (request_progress_strobe === 1'b1)
            begin
                check_val(BW'(prog_q.size() != 0), BW'(1));
                if (prog_q.size() != 0)
                    check_val(BW'(request_progress_out), BW'(prog_q.pop_front()));
            end
        end
    end

    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        stall = 1'b0;
        prog_en = 1'b1;
        first_beat = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb_xfer(1'b0, rqsp_pkg::RQSP_CTRL_OFS, 32'h0);
        check_reg(rd, 32'h0000_0003);
        apb_xfer(1'b0, 12'h010, 32'h0);
        check_reg({err, rd[30:0]}, 32'h8000_0000);
        // back to back packets, one-beat, short last beat, full last beat
        app.send(1, 8'hf1, 4'h1);
        app.send(3, 8'h37, 4'h2);
        app.send(2, 8'hff, 4'h3);
        app.idle();
        // a completion that must not pass these posted requests waits for their numbers
        drain();
        // far side stalls while the application holds its beat
        stall <= 1'b1;
        app.send(4, 8'h07, 4'h4);
        app.send(1, 8'h01, 4'h5);
        app.idle();
        drain();
        stall <= 1'b0;
        fork
            app.send(4, 8'h0f, 4'h6);
            begin
                repeat (2) @(posedge pclk);
                ce <= 1'b0;
                repeat (3) @(posedge pclk);
                ce <= 1'b1;
            end
        join
        app.idle();
        drain();
        // accept disabled: the offered beat must wait
        apb_xfer(1'b1, rqsp_pkg::RQSP_CTRL_OFS, 32'h0000_0002);
        n = beats_in;
        fork
            app.send(1, 8'h03, 4'h7);
            begin
                repeat (4) @(posedge pclk);
                check_val(BW'(beats_in), BW'(n));
                apb_xfer(1'b1, rqsp_pkg::RQSP_CTRL_OFS, 32'h0000_0003);
            end
        join
        app.idle();
        drain();
        apb_xfer(1'b1, rqsp_pkg::RQSP_CTRL_OFS, 32'h0000_0001);
        prog_en = 1'b0;
        app.send(2, 8'h03, 4'h8);
        app.idle();
        drain();
        repeat (8) @(posedge pclk);
        apb_xfer(1'b1, rqsp_pkg::RQSP_CTRL_OFS, 32'h0000_0003);
        prog_en = 1'b1;
        apb_xfer(1'b0, rqsp_pkg::RQSP_PKT_COUNT_OFS, 32'h0);
        check_reg(rd, 32'(pkts_in));
        apb_xfer(1'b0, rqsp_pkg::RQSP_BEAT_COUNT_OFS, 32'h0);
        check_reg(rd, 32'(beats_in));
        apb_xfer(1'b1, rqsp_pkg::RQSP_CTRL_OFS, 32'h0000_0007);
        apb_xfer(1'b0, rqsp_pkg::RQSP_BEAT_COUNT_OFS, 32'h0);
        check_reg(rd, 32'h0);
        stop_test();
    end
endmodule : rqsp_request_port_test

`default_nettype wire
